// ==== rtl/rcpf_defines.svh ====
/*
 register offsets, field positions, reset values and the derived mode
 constants of the receive front-end configuration bank.
 assumes an AXI4-Lite slave with byte address equal to four times the index.
*/
`ifndef RCPF_DEFINES_SVH
`define RCPF_DEFINES_SVH
// register indices; the byte address is four times the index
`define RCPF_IDX_PHASE0 8'hc1
`define RCPF_IDX_PHASE1 8'hc2
`define RCPF_IDX_PHASE2 8'hc3
`define RCPF_IDX_PHASE3 8'hc4
`define RCPF_IDX_SHUTDOWN 8'hc5
`define RCPF_IDX_POWER 8'hc6
`define RCPF_IDX_FILTER 8'hc7
`define RCPF_IDX_ECONOMY 8'hc8
// power control field positions
`define RCPF_BIT_QUICK 0
`define RCPF_BIT_FULL 1
`define RCPF_BIT_PREAMP 2
`define RCPF_BIT_LOWPASS 3
// filter configuration field positions
`define RCPF_LSB_AA 7
`define RCPF_BIT_HPBYP 9
`define RCPF_LSB_HP 10
// economy register field position
`define RCPF_BIT_ECON 12
// reset value of every field
`define RCPF_RESET 16'h0000
// phase step in tenths of a degree
`define RCPF_PHASE_STEP_DDEG 12'd225
// high-pass corner in kHz per code
`define RCPF_HP_KHZ_0 10'd75
`define RCPF_HP_KHZ_1 10'd150
`define RCPF_HP_KHZ_2 10'd300
`define RCPF_HP_KHZ_3 10'd600
// low-pass corner in hundreds of kHz, full-power modes
`define RCPF_AA_HKHZ_0 9'd150
`define RCPF_AA_HKHZ_1 9'd100
`define RCPF_AA_HKHZ_2 9'd250
`define RCPF_AA_HKHZ_3 9'd200
// axi responses
`define RCPF_RESP_OKAY 2'b00
`define RCPF_RESP_SLVERR 2'b10
`endif

// ==== rtl/rcpf_pkg.sv ====
/*
 types of the receive front-end configuration bank.
 assumes rcpf_defines.svh is included where constants are needed.
*/
package rcpf_pkg;
   // bus handshake state
   typedef enum logic [1:0] {
      RCPF_IDLE = 2'b00,
      RCPF_RESP = 2'b01
   } rcpf_bus_type;
   // analog control levels of one channel
   typedef struct packed {
      logic shutdown;     // amplifier, filter, mixer off
      logic [3:0] phase;  // mixer phase code
   } rcpf_chan_type;
   // block-wide analog controls
   typedef struct packed {
      logic lowpass_shutdown;
      logic preamp_shutdown;
      logic full_front_end_shutdown;
      logic quick_wake_shutdown;
      logic highpass_bypass;
      logic [1:0] highpass_corner_select;
      logic [1:0] antialias_corner_select;
      logic economy_power_select;
   } rcpf_ctrl_type;
   // all state of the bank
   typedef struct packed {
      logic [15:0] phase0;
      logic [15:0] phase1;
      logic [15:0] phase2;
      logic [15:0] phase3;
      logic [15:0] shutdown;
      logic [15:0] power;
      logic [15:0] filter;
      logic [15:0] economy;
      rcpf_bus_type wr_st;
      logic [1:0] bresp;
      rcpf_bus_type rd_st;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rcpf_state_type;
endpackage : rcpf_pkg

// ==== rtl/rcpf_regs.sv ====
/*
 receive-chain power and filter register bank with an AXI4-Lite slave.
 assumes a single 25 MHz clock, asynchronous active-high reset, and a
 master that keeps one write and one read in flight at most.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rcpf_defines.svh"
module rcpf_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output rcpf_pkg::rcpf_chan_type [15:0] chan_ctrl,
   output rcpf_pkg::rcpf_ctrl_type block_ctrl,
   output logic [11:0] phase_ddeg [15:0],
   output logic [9:0] highpass_khz,
   output logic [8:0] antialias_hkhz,
   output logic converter_shutdown
);
   rcpf_pkg::rcpf_state_type st;      // registered state
   rcpf_pkg::rcpf_state_type next_st; // next state
   logic [7:0] wr_idx; // write word index
   logic [7:0] rd_idx; // read word index
   logic [15:0] wmask; // byte-lane mask for the low half
   logic [255:0] phase_flat; // four phase words as one vector
   logic [8:0] aa_full; // full-power corner before economy halving

   assign wr_idx = s_axi_awaddr[9:2];
   assign rd_idx = s_axi_araddr[9:2];
   assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

   // write takes address and data together so neither can be stranded
   assign s_axi_awready = (st.wr_st == rcpf_pkg::RCPF_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready = s_axi_awready;
   assign s_axi_bvalid = (st.wr_st == rcpf_pkg::RCPF_RESP);
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = (st.rd_st == rcpf_pkg::RCPF_IDLE);
   assign s_axi_rvalid = (st.rd_st == rcpf_pkg::RCPF_RESP);
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // merge a write into a word under the byte strobes
   function automatic logic [15:0] rcpf_merge(input logic [15:0] old, input logic [15:0] wd,
         input logic [15:0] m);
      rcpf_merge = (old & ~m) | (wd & m);
   endfunction : rcpf_merge

   // next-state logic for both channels
   always_comb begin
      next_st = st;
      // write channel
      if (st.wr_st == rcpf_pkg::RCPF_IDLE) begin
         if (s_axi_awready) begin
            next_st.wr_st = rcpf_pkg::RCPF_RESP;
            next_st.bresp = `RCPF_RESP_OKAY;
            // every field is stored as written; unused bits kept as given
            case (wr_idx)
               `RCPF_IDX_PHASE0: next_st.phase0 = rcpf_merge(st.phase0, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_PHASE1: next_st.phase1 = rcpf_merge(st.phase1, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_PHASE2: next_st.phase2 = rcpf_merge(st.phase2, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_PHASE3: next_st.phase3 = rcpf_merge(st.phase3, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_SHUTDOWN: begin
                  next_st.shutdown = rcpf_merge(st.shutdown, s_axi_wdata[15:0], wmask);
               end
               `RCPF_IDX_POWER: next_st.power = rcpf_merge(st.power, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_FILTER: next_st.filter = rcpf_merge(st.filter, s_axi_wdata[15:0], wmask);
               `RCPF_IDX_ECONOMY: begin
                  next_st.economy = rcpf_merge(st.economy, s_axi_wdata[15:0], wmask);
               end
               // unmapped: answer with an error, nothing stored
               default: next_st.bresp = `RCPF_RESP_SLVERR;
            endcase
         end
      end else if (s_axi_bready) begin
         next_st.wr_st = rcpf_pkg::RCPF_IDLE;
      end
      // read channel
      if (st.rd_st == rcpf_pkg::RCPF_IDLE) begin
         if (s_axi_arvalid) begin
            next_st.rd_st = rcpf_pkg::RCPF_RESP;
            next_st.rresp = `RCPF_RESP_OKAY;
            next_st.rdata = 32'h00000000;
            // upper half always reads zero
            case (rd_idx)
               `RCPF_IDX_PHASE0: next_st.rdata[15:0] = st.phase0;
               `RCPF_IDX_PHASE1: next_st.rdata[15:0] = st.phase1;
               `RCPF_IDX_PHASE2: next_st.rdata[15:0] = st.phase2;
               `RCPF_IDX_PHASE3: next_st.rdata[15:0] = st.phase3;
               `RCPF_IDX_SHUTDOWN: next_st.rdata[15:0] = st.shutdown;
               `RCPF_IDX_POWER: next_st.rdata[15:0] = st.power;
               `RCPF_IDX_FILTER: next_st.rdata[15:0] = st.filter;
               `RCPF_IDX_ECONOMY: next_st.rdata[15:0] = st.economy;
               // unmapped: zero data with error
               default: next_st.rresp = `RCPF_RESP_SLVERR;
            endcase
         end
      end else if (s_axi_rready) begin
         next_st.rd_st = rcpf_pkg::RCPF_IDLE;
      end
   end

   // state register; every field starts at zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // phase words stacked so channel n sits at bits 4n+3..4n
   assign phase_flat = {192'h0, st.phase3, st.phase2, st.phase1, st.phase0};

   // per-channel controls, one slice per channel
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_chan
         // shutdown bit gi belongs to channel gi+1 only
         assign chan_ctrl[gi].shutdown = st.shutdown[gi];
         // highest channel of each group in the top nibble
         assign chan_ctrl[gi].phase = phase_flat[4*gi +: 4];
         // phase in tenths of a degree, code times 22.5 degrees
         assign phase_ddeg[gi] = 12'(phase_flat[4*gi +: 4] * `RCPF_PHASE_STEP_DDEG);
      end
   endgenerate

   // block controls straight from the stored fields
   assign block_ctrl.lowpass_shutdown = st.power[`RCPF_BIT_LOWPASS];
   assign block_ctrl.preamp_shutdown = st.power[`RCPF_BIT_PREAMP];
   assign block_ctrl.full_front_end_shutdown = st.power[`RCPF_BIT_FULL];
   assign block_ctrl.quick_wake_shutdown = st.power[`RCPF_BIT_QUICK];
   assign block_ctrl.highpass_bypass = st.filter[`RCPF_BIT_HPBYP];
   assign block_ctrl.highpass_corner_select = st.filter[`RCPF_LSB_HP +: 2];
   assign block_ctrl.antialias_corner_select = st.filter[`RCPF_LSB_AA +: 2];
   assign block_ctrl.economy_power_select = st.economy[`RCPF_BIT_ECON];

   // converter is never shut down by this bank
   assign converter_shutdown = 1'b0;

   // high-pass corner decode
   always_comb begin
      case (st.filter[`RCPF_LSB_HP +: 2])
         2'h0: highpass_khz = `RCPF_HP_KHZ_0;
         2'h1: highpass_khz = `RCPF_HP_KHZ_1;
         2'h2: highpass_khz = `RCPF_HP_KHZ_2;
         default: highpass_khz = `RCPF_HP_KHZ_3;
      endcase
   end

   // low-pass corner decode; economy mode halves it
   always_comb begin
      case (st.filter[`RCPF_LSB_AA +: 2])
         2'h0: aa_full = `RCPF_AA_HKHZ_0;
         2'h1: aa_full = `RCPF_AA_HKHZ_1;
         2'h2: aa_full = `RCPF_AA_HKHZ_2;
         default: aa_full = `RCPF_AA_HKHZ_3;
      endcase
      antialias_hkhz = st.economy[`RCPF_BIT_ECON] ? (aa_full >> 1) : aa_full;
   end

   // bus checks: every answer comes one cycle after acceptance and stands until taken
   a_write_answer: assert property (@(posedge clk) disable iff (rst)
      s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");

   // address and data are always taken together, so neither is stranded
   a_wr_pair: assert property (@(posedge clk) disable iff (rst)
      s_axi_wready == s_axi_awready)
      else $error("write halves split");

   // no new write while the previous answer is still waiting
   a_wr_busy: assert property (@(posedge clk) disable iff (rst)
      s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");

   // write answer stands with a steady code until bready
   a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");

   // a write to the filter register is answered okay
   a_wr_okay: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_FILTER) |=> s_axi_bresp == `RCPF_RESP_OKAY)
      else $error("mapped write refused");

   // an index below the bank is refused, so software sees an error rather than silence
   a_wr_unmapped: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx < `RCPF_IDX_PHASE0) |=> s_axi_bresp == `RCPF_RESP_SLVERR)
      else $error("unmapped write accepted");

   // a read answers one cycle after acceptance
   a_read_answer: assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read response late");

   // no new read while the previous data still waits
   a_rd_busy: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");

   // read data stands until taken
   a_read_hold: assert property (@(posedge clk) disable iff (rst)
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   // the upper half of every read word is zero
   a_rdata_upper: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read upper half not zero");

   // channel checks: shutdown write shows on the channel one level next cycle
   a_chan_shut: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_SHUTDOWN && s_axi_wstrb[0])
      |=> chan_ctrl[0].shutdown == $past(s_axi_wdata[0]))
      else $error("channel one shutdown not applied");

   // channel sixteen sits in the top bit of the word
   a_chan_top_shut: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_SHUTDOWN && s_axi_wstrb[1])
      |=> chan_ctrl[15].shutdown == $past(s_axi_wdata[15]))
      else $error("channel sixteen shutdown not applied");

   // a channel shutdown write leaves every block-wide level alone
   a_shut_isolate: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_SHUTDOWN) |=> $stable(block_ctrl))
      else $error("channel shutdown leaked");

   // a channel shutdown never reaches the converter
   a_conv_free: assert property (@(posedge clk) disable iff (rst)
      (st.shutdown != 16'h0 || st.power[1:0] != 2'b00) |-> !converter_shutdown)
      else $error("converter affected");

   // block checks: low-pass shutdown follows power bit 3 of the written word
   a_lowpass_shut: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_POWER && s_axi_wstrb[0])
      |=> block_ctrl.lowpass_shutdown == $past(s_axi_wdata[3]))
      else $error("lowpass shutdown mismatch");

   // preamp shutdown follows power bit 2
   a_preamp_shut: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_POWER && s_axi_wstrb[0])
      |=> block_ctrl.preamp_shutdown == $past(s_axi_wdata[2]))
      else $error("preamp shutdown mismatch");

   // full shutdown level follows power bit 1
   a_full_shut: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_POWER && s_axi_wstrb[0])
      |=> block_ctrl.full_front_end_shutdown == $past(s_axi_wdata[1]))
      else $error("full shutdown mismatch");

   // quick wake shutdown follows power bit 0
   a_quick_write: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_POWER && s_axi_wstrb[0])
      |=> block_ctrl.quick_wake_shutdown == $past(s_axi_wdata[0]))
      else $error("quick shutdown write mismatch");

   // quick wake and preamp levels track the stored word at all times
   a_quick_shut: assert property (@(posedge clk) disable iff (rst)
      block_ctrl.quick_wake_shutdown == st.power[0] && block_ctrl.preamp_shutdown == st.power[2])
      else $error("quick or preamp mismatch");

   // the global power bits stay on the front-end die
   a_conv_power: assert property (@(posedge clk) disable iff (rst)
      (block_ctrl.full_front_end_shutdown || block_ctrl.quick_wake_shutdown)
      |-> !converter_shutdown)
      else $error("converter shut by global bit");

   // filter checks: highest high-pass code gives 600 kHz
   a_hp_top: assert property (@(posedge clk) disable iff (rst)
      st.filter[11:10] == 2'b11 |-> highpass_khz == 10'd600)
      else $error("highpass corner wrong");

   // lowest high-pass code gives 75 kHz
   a_hp_base: assert property (@(posedge clk) disable iff (rst)
      st.filter[11:10] == 2'b00 |-> highpass_khz == 10'd75)
      else $error("highpass base corner wrong");

   // bypass level follows bit 9 of the written word
   a_bypass_write: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_FILTER && s_axi_wstrb[1])
      |=> block_ctrl.highpass_bypass == $past(s_axi_wdata[9]))
      else $error("highpass bypass mismatch");

   // economy halves the low-pass corner: 15 MHz becomes 7.5 MHz
   a_aa_half: assert property (@(posedge clk) disable iff (rst)
      (st.economy[12] && st.filter[8:7] == 2'b00) |-> antialias_hkhz == 9'd75)
      else $error("economy corner wrong");

   // full-power mode keeps the whole corner: code 10 is 25 MHz
   a_aa_full: assert property (@(posedge clk) disable iff (rst)
      (!st.economy[12] && st.filter[8:7] == 2'b10) |-> antialias_hkhz == 9'd250)
      else $error("full-power corner wrong");

   // economy with code 11 gives 10 MHz
   a_aa_low_ten: assert property (@(posedge clk) disable iff (rst)
      (st.economy[12] && st.filter[8:7] == 2'b11) |-> antialias_hkhz == 9'd100)
      else $error("economy top corner wrong");

   // economy level follows bit 12 of the written word
   a_econ_write: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_ECONOMY && s_axi_wstrb[1])
      |=> block_ctrl.economy_power_select == $past(s_axi_wdata[12]))
      else $error("economy select mismatch");

   // phase checks: channel sixteen from the top nibble of the last word
   a_phase_top: assert property (@(posedge clk) disable iff (rst)
      phase_ddeg[15] == 12'(st.phase3[15:12] * 12'd225))
      else $error("phase degrees wrong");

   // channel one from the bottom nibble of the first word
   a_phase_low: assert property (@(posedge clk) disable iff (rst)
      phase_ddeg[0] == 12'(st.phase0[3:0] * 12'd225))
      else $error("channel one phase wrong");

   // channel four takes the top nibble of the first word
   a_phase_pack: assert property (@(posedge clk) disable iff (rst)
      (s_axi_awready && wr_idx == `RCPF_IDX_PHASE0 && s_axi_wstrb[1])
      |=> chan_ctrl[3].phase == $past(s_axi_wdata[15:12]))
      else $error("phase packing wrong");
endmodule : rcpf_regs

// ==== verif/rcpf_regs_tb.sv ====
/*
 self-checking bench of the receive front-end configuration bank.
 assumes rcpf_regs with an AXI4-Lite slave at byte address 4*index, 25 MHz clock.
*/
`timescale 1ns/100ps
`include "rcpf_defines.svh"
module rcpf_regs_tb;
   logic clk;  // 25 MHz system clock
   logic rst;  // active-high reset
   logic [31:0] awaddr, wdata, araddr;  // bus request payloads
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;  // slave answers
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   rcpf_pkg::rcpf_chan_type [15:0] chan_ctrl;  // per-channel levels
   rcpf_pkg::rcpf_ctrl_type block_ctrl;  // block-wide levels
   logic [11:0] phase_ddeg [15:0];
   logic [9:0] highpass_khz;
   logic [8:0] antialias_hkhz;
   logic converter_shutdown;
   int err_count = 0;
   int tests_run = 0;
   logic [1:0] resp;
   logic [31:0] data;
   rcpf_regs rcpf_regs_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .chan_ctrl(chan_ctrl), .block_ctrl(block_ctrl),
      .phase_ddeg(phase_ddeg), .highpass_khz(highpass_khz),
      .antialias_hkhz(antialias_hkhz), .converter_shutdown(converter_shutdown));
   // free-running clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // one comparison; four-state equality so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
         err_count++;
      end
   endtask : chk
   // write: address and data offered together, held until taken, then await bvalid
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= {22'h000000, idx, 2'b00};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(posedge clk); n++; end while (!(awready && wready) && n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(posedge clk); n++; end while (!bvalid && n < 100);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);  // keeps the next request out of this edge's time step
   endtask : wr
   // read: arvalid held until taken, rready held until rvalid seen
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= {22'h000000, idx, 2'b00};
      arvalid <= 1'b1;
      do begin @(posedge clk); n++; end while (!arready && n < 50);
      arvalid <= 1'b0;
      @(posedge clk);  // one edge with rready low, so held read data is exercised
      rready <= 1'b1;
      do begin @(posedge clk); n++; end while (!rvalid && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   // full-word write, then read back and compare with what was written
   task automatic wchk(input logic [7:0] idx, input logic [31:0] d);
      wr(idx, d, 4'hf, resp);
      chk({30'h0, resp}, 32'h0, "write response");
      rd(idx, data, resp);
      chk(data, d, "read back");
   endtask : wchk
   // every register reads zero after reset, outputs at their zero-code levels
   task automatic t_reset;
      for (int i = 8'hc1; i <= 8'hc8; i++) begin
         rd(8'(i), data, resp);
         chk(data, 32'h0, "reset value");
      end
      chk(32'(highpass_khz), 32'h4b, "hp corner at reset");
      chk(32'(antialias_hkhz), 32'h96, "aa corner at reset");
   endtask : t_reset
   // end channels shut down, neighbours and converter untouched
   task automatic t_shutdown;
      wchk(`RCPF_IDX_SHUTDOWN, 32'h00008001);
      chk(32'({chan_ctrl[15].shutdown, chan_ctrl[14].shutdown}), 32'h2, "ch16 ch15");
      chk(32'({chan_ctrl[1].shutdown, chan_ctrl[0].shutdown}), 32'h1, "ch2 ch1");
      chk(32'({block_ctrl.full_front_end_shutdown, converter_shutdown}), 32'h0, "side");
      wchk(`RCPF_IDX_SHUTDOWN, 32'h0);
   endtask : t_shutdown
   // each power control bit alone drives its own control level only
   task automatic t_power;
      for (int b = 0; b < 4; b++) begin
         wchk(`RCPF_IDX_POWER, 32'h1 << b);
         chk(32'({block_ctrl.lowpass_shutdown, block_ctrl.preamp_shutdown,
                  block_ctrl.full_front_end_shutdown, block_ctrl.quick_wake_shutdown}),
             32'h1 << b, "power levels");
         chk(32'(converter_shutdown), 32'h0, "converter");
      end
      wchk(`RCPF_IDX_POWER, 32'h0);
   endtask : t_power
   // all corner codes, antialias in full and economy modes, bypass toggled
   task automatic t_filter;
      logic [9:0] hp [4] = '{10'h04b, 10'h096, 10'h12c, 10'h258};  // 75 150 300 600 kHz
      logic [8:0] aa [4] = '{9'h096, 9'h064, 9'h0fa, 9'h0c8};  // 15 10 25 20 MHz
      for (int c = 0; c < 4; c++) begin
         wchk(`RCPF_IDX_FILTER, (c << 10) | ((c & 1) << 9) | (c << 7));
         chk(32'(highpass_khz), 32'(hp[c]), "hp corner");
         chk(32'(block_ctrl.highpass_corner_select), c, "hp code");
         chk(32'(block_ctrl.antialias_corner_select), c, "aa code");
         chk(32'(block_ctrl.highpass_bypass), c & 1, "hp bypass");
         chk(32'(antialias_hkhz), 32'(aa[c]), "aa corner");
         wchk(`RCPF_IDX_ECONOMY, 32'h1000);
         chk(32'(block_ctrl.economy_power_select), 32'h1, "economy level");
         chk(32'(antialias_hkhz), 32'(aa[c] >> 1), "aa economy");
         wchk(`RCPF_IDX_ECONOMY, 32'h0);
      end
   endtask : t_filter
   // every phase code on channels 1 and 16, at the two ends of their words
   task automatic t_phase;
      for (int n = 0; n < 16; n++) begin
         wchk(`RCPF_IDX_PHASE3, n << 12);
         wchk(`RCPF_IDX_PHASE0, n);
         chk(32'(chan_ctrl[15].phase), n, "ch16 code");
         chk(32'(phase_ddeg[15]), n * 225, "ch16 phase");
         chk(32'(phase_ddeg[0]), n * 225, "ch1 phase");
      end
   endtask : t_phase
   // distinct codes on all sixteen channels, eight channels shut down in the pattern 5a5a
   task automatic t_allphase;
      for (int k = 0; k < 4; k++) begin
         wchk(8'(`RCPF_IDX_PHASE0 + k),
              ((4 * k + 3) << 12) | ((4 * k + 2) << 8) | ((4 * k + 1) << 4) | (4 * k));
      end
      wchk(`RCPF_IDX_SHUTDOWN, 32'h00005a5a);
      for (int i = 0; i < 16; i++) begin
         chk(32'(chan_ctrl[i].phase), i, "channel code");
         chk(32'(phase_ddeg[i]), i * 225, "channel phase");
         chk(32'(chan_ctrl[i].shutdown), (32'h5a5a >> i) & 1, "channel shutdown");
      end
   endtask : t_allphase
   // reset in mid-run brings every register and level back to zero
   task automatic t_rerst;
      wchk(`RCPF_IDX_FILTER, 32'h00000d80);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 8'hc1; i <= 8'hc8; i++) begin
         rd(8'(i), data, resp);
         chk(data, 32'h0, "value after second reset");
      end
      chk(32'(chan_ctrl[15].phase), 32'h0, "ch16 code after reset");
      chk(32'(highpass_khz), 32'h4b, "hp corner after reset");
   endtask : t_rerst
   // byte strobe honoured, unmapped place refused with an error response
   task automatic t_bus;
      wr(`RCPF_IDX_SHUTDOWN, 32'h0000ffff, 4'h2, resp);
      rd(`RCPF_IDX_SHUTDOWN, data, resp);
      chk(data, 32'h0000ff00, "strobe lane");
      wr(8'h10, 32'h1, 4'hf, resp);
      chk({30'h0, resp}, 32'h2, "unmapped write");
      rd(8'h10, data, resp);
      chk({30'h0, resp}, 32'h2, "unmapped read response");
      chk(data, 32'h0, "unmapped read data");
   endtask : t_bus
   // counts, then verdict; the only place the run ends
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      #(40 * 6000);
      err_count++;
      report_and_stop;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr, wstrb} = 100'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_shutdown;
      t_power;
      t_filter;
      t_phase;
      t_allphase;
      t_rerst;
      t_bus;
      report_and_stop;
   end
endmodule : rcpf_regs_tb
